// ===== design/dtts_pkg.sv
// Purpose: Shared constants for the digital test tone source.
// Assumes: Shelf PCM timing arrives as plain pins from outside the clock.
// Notes:   Tone table levels are selected by a parameter of the top.
`default_nettype none
package dtts_pkg;
  localparam int unsigned SAMPLE_W   = 8;   // Bits in one PCM sample.
  localparam int unsigned ROM_DEPTH  = 64;  // Samples in one tone table.
  localparam int unsigned ADDR_W     = 6;   // Width of the sample address.
  localparam int unsigned BITCNT_W   = 3;   // Width of the bit counter.
  localparam int unsigned NUM_TRUNKS = 2;   // Trunk logic buffers.
  localparam logic [ADDR_W-1:0] ADDR_LAST  = 6'h3f;  // Last sample address.
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 6'h00;  // First address.
  localparam logic [SAMPLE_W-1:0] PCM_ZERO = 8'hd5;  // Zero-amplitude code.
  localparam logic [BITCNT_W-1:0] BIT_LAST = 3'h7;   // Last bit of a word.
  localparam logic [BITCNT_W-1:0] BIT_FIRST = 3'h0;  // First bit of a word.
  // Tone level variants held in the table.
  typedef enum logic [1:0] {
    DTTS_LVL_M10,
    DTTS_LVL_M15,
    DTTS_LVL_M20
  } dtts_level_t;
endpackage
`default_nettype wire

// ===== design/dtts_tone_rom.sv
// Purpose: Stored 1004 Hz sine table with one fixed level per build.
// Assumes: 64 samples per table; the table is only read, never written.
// Notes:   Samples are sign-magnitude with 8 kHz sampling in mind.
`default_nettype none
module dtts_tone_rom
  import dtts_pkg::*;
#(
  parameter dtts_level_t LEVEL = DTTS_LVL_M10  // Fixed table level.
)
(
  input  wire logic                i_clk,   // Core clock.
  input  wire logic [ADDR_W-1:0]   i_addr,  // Sample address.
  output logic      [SAMPLE_W-1:0] o_data   // Registered sample word.
);

  // Quarter-wave magnitudes; a shift sets the level with no variation.
  function automatic logic [SAMPLE_W-1:0] sample_at(
    input logic [ADDR_W-1:0] a);
    logic [6:0] mag;
    logic [6:0] phase;
    logic [6:0] q;
    mag   = 7'h00;
    phase = {1'b0, a} * 7'h05;
    q     = (phase[5] == 1'b0) ? {2'b00, phase[4:0]}
                               : 7'h1f - {2'b00, phase[4:0]};
    mag   = q * 7'h02 + 7'h10;
    unique case (LEVEL)
      DTTS_LVL_M10: mag = mag;
      DTTS_LVL_M15: mag = mag >> 1;
      default:      mag = mag >> 2;
    endcase
    return {phase[6], mag};
  endfunction

  // Registered read keeps the serialiser load timing fixed.
  always_ff @(posedge i_clk)
  begin
    o_data <= sample_at(i_addr);
  end

endmodule
`default_nettype wire

// ===== design/dtts_tone_source.sv
// Purpose: Test-line tone source with two trunk logic buffers.
// Assumes: Shelf frame and bit strobes are asynchronous pins.
// Notes:   One shared tone circuit feeds either trunk slot.
//          Pin levels must stand one clock to be seen.
`default_nettype none
module dtts_tone_source
  import dtts_pkg::*;
#(
  parameter dtts_level_t LEVEL = DTTS_LVL_M10  // Tone table level.
)
(
  input  wire logic                  i_clk,        // 250 MHz clock.
  input  wire logic                  i_rst,        // Sync reset, high.
  input  wire logic [NUM_TRUNKS-1:0] i_enable,     // Per-trunk test request.
  input  wire logic [NUM_TRUNKS-1:0] i_tone_sel,   // Tone-select points.
  input  wire logic [NUM_TRUNKS-1:0] i_slot,       // Channel slot per trunk.
  input  wire logic                  i_frame,      // PCM frame strobe.
  input  wire logic                  i_bit_clk,    // PCM bit clock.
  output logic      [NUM_TRUNKS-1:0] o_tx_data,    // Transmit PCM bus bits.
  output logic      [NUM_TRUNKS-1:0] o_tx_en,      // Bus drive per trunk.
  output logic      [NUM_TRUNKS-1:0] o_sel_scan,   // Select scan points.
  output logic                       o_active      // Tone circuit running.
);

  // Two-flop synchronisers for every pin input. The pins have no relation
  // to this clock, so no logic ever reads a first stage.
  logic [NUM_TRUNKS-1:0] en_meta_ff, en_ff, sel_meta_ff, sel_ff;
  logic [NUM_TRUNKS-1:0] slot_meta_ff, slot_ff;
  logic                  frm_meta_ff, frm_ff, frm_d_ff;
  logic                  bck_meta_ff, bck_ff, bck_d_ff;

  // Control pins from the controller: requests, selects and slots.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      en_meta_ff   <= '0;
      en_ff        <= '0;
      sel_meta_ff  <= '0;
      sel_ff       <= '0;
      slot_meta_ff <= '0;
      slot_ff      <= '0;
    end
    else
    begin
      en_meta_ff   <= i_enable;
      en_ff        <= en_meta_ff;
      sel_meta_ff  <= i_tone_sel;
      sel_ff       <= sel_meta_ff;
      slot_meta_ff <= i_slot;
      slot_ff      <= slot_meta_ff;
    end
  end

  // Timing pins from the shelf; a third stage keeps the old level so
  // that each edge is seen exactly once.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      frm_meta_ff  <= 1'b0;
      frm_ff       <= 1'b0;
      frm_d_ff     <= 1'b0;
      bck_meta_ff  <= 1'b0;
      bck_ff       <= 1'b0;
      bck_d_ff     <= 1'b0;
    end
    else
    begin
      frm_meta_ff  <= i_frame;
      frm_ff       <= frm_meta_ff;
      frm_d_ff     <= frm_ff;
      bck_meta_ff  <= i_bit_clk;
      bck_ff       <= bck_meta_ff;
      bck_d_ff     <= bck_ff;
    end
  end

  // Rising-edge decode, shared by the frame and bit strobes.
  function automatic logic rise_of(
    input logic now_lvl,   // Level after the second stage.
    input logic old_lvl);  // Level one clock earlier.
    return now_lvl & ~old_lvl;
  endfunction

  // Edge strobes are taken from the second and third stages only.
  // A pin level shorter than one clock may be missed altogether.
  logic frame_start;
  logic bit_tick;
  logic run;
  assign frame_start = rise_of(frm_ff, frm_d_ff);
  assign bit_tick    = rise_of(bck_ff, bck_d_ff);
  assign run         = |en_ff;

  // Address counter: starts on request, wraps for a continuous tone.
  // Holding the first address while idle makes every test open on the
  // same sample; both trunks share it, so a late trunk joins mid-cycle.
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  always_comb
  begin
    nxt_addr = addr_ff;
    if (!run)
      nxt_addr = ADDR_FIRST;
    else if (frame_start)
      nxt_addr = (addr_ff == ADDR_LAST) ? ADDR_FIRST
                                        : addr_ff + 6'h01;
  end

  // Address register; reset parks it on the first sample.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      addr_ff <= ADDR_FIRST;
    else
      addr_ff <= nxt_addr;
  end

  // Running flag: any trunk's request keeps the shared circuit going.
  // It follows the synchronised request, so it lags the pin by 3 clocks.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_active <= 1'b0;
    else
      o_active <= run;
  end

  // Tone table; its registered read adds a clock that frames hide.
  logic [SAMPLE_W-1:0] rom_word;
  dtts_tone_rom #(
    .LEVEL (LEVEL)
  ) u_rom (
    .i_clk  (i_clk),
    .i_addr (addr_ff),
    .o_data (rom_word)
  );

  // Output buffer: one word per frame, shifted MSB first on bit ticks.
  // The ROM word settles long before the next frame, since frames are
  // far slower than the core clock.
  // Ticks past the eighth bit are ignored, so stray edges cannot shift
  // zeros onto the line.
  logic [SAMPLE_W-1:0] shift_ff;
  logic [BITCNT_W-1:0] bit_ff;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      shift_ff <= PCM_ZERO;
      bit_ff   <= BIT_FIRST;
    end
    else if (frame_start)
    begin
      shift_ff <= rom_word;
      bit_ff   <= BIT_FIRST;
    end
    else if (bit_tick && bit_ff != BIT_LAST)
    begin
      shift_ff <= {shift_ff[SAMPLE_W-2:0], 1'b0};
      bit_ff   <= bit_ff + 3'h1;
    end
  end

  // Quiet code is serialised in step with the tone bits.
  // Indexing it by the shared bit counter keeps both on one bit clock.
  logic [BITCNT_W-1:0] quiet_idx;
  assign quiet_idx = BIT_LAST - bit_ff;

  // Trunk logic buffers: each relays data and control for its trunk.
  // Silence must be a valid zero code, not an idle bus, so the bus is
  // driven in the slot whenever the trunk is enabled.
  genvar t;
  generate
    for (t = 0; t < NUM_TRUNKS; t++)
    begin : g_trunk
      // Control relay: scan point and bus drive for this trunk.
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
        begin
          o_tx_en[t]    <= 1'b0;
          o_sel_scan[t] <= 1'b0;
        end
        else
        begin
          o_sel_scan[t] <= sel_ff[t];
          o_tx_en[t]    <= en_ff[t] & slot_ff[t];
        end
      end

      // Data relay: tone bit or quiet bit, with the same timing for both.
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
          o_tx_data[t] <= 1'b0;
        else if (sel_ff[t])
          o_tx_data[t] <= shift_ff[SAMPLE_W-1];
        else
          o_tx_data[t] <= PCM_ZERO[quiet_idx];
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== testbench/dtts_checker.sv
// Purpose: Port assertions for the tone source.
// Assumes: Pins stand long enough to pass the synchronisers.
// Notes:   Five-cycle windows cover the sync lag.
`default_nettype none
module dtts_checker
  import dtts_pkg::*;
(
  input wire logic                  i_clk,      // Clock.
  input wire logic                  i_rst,      // Reset.
  input wire logic [NUM_TRUNKS-1:0] i_enable,   // Requests.
  input wire logic [NUM_TRUNKS-1:0] i_tone_sel, // Selects.
  input wire logic [NUM_TRUNKS-1:0] i_slot,     // Slots.
  input wire logic                  i_frame,    // Frame.
  input wire logic                  i_bit_clk,  // Bit clock.
  input wire logic [NUM_TRUNKS-1:0] o_tx_data,  // Bits.
  input wire logic [NUM_TRUNKS-1:0] o_tx_en,    // Drives.
  input wire logic [NUM_TRUNKS-1:0] o_sel_scan, // Scans.
  input wire logic                  o_active    // Running.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Outputs must track held inputs once the sync lag is over.
  a_req_start: assert property ((|i_enable)[*5] |-> o_active)
    else $error("active missing");
  a_req_gone: assert property ((~|i_enable)[*5] |-> !o_active)
    else $error("active stuck");
  a_scan_copy: assert property ($stable(i_tone_sel)[*5] |->
    o_sel_scan == i_tone_sel) else $error("scan wrong");
  a_drive_on: assert property ((i_enable[0] && i_slot[0])[*5]
    |-> o_tx_en[0]) else $error("drive missing");
  a_drive_off: assert property ((!i_slot[0])[*5] |->
    !o_tx_en[0]) else $error("drive outside slot");
  a_bit_paced: assert property ((!i_frame && !i_bit_clk
    && $stable(i_tone_sel))[*8] |-> $stable(o_tx_data))
    else $error("bit moved");
  a_quiet_msb: assert property ($rose(i_frame) && !i_tone_sel[1]
    && !$past(i_tone_sel[1], 4) && i_enable[1] && $past(i_enable[1], 4)
    |-> ##5 o_tx_data[1] == PCM_ZERO[7]) else $error("quiet msb");
  a_rst_clear: assert property (disable iff (1'b0) i_rst |=>
    !o_active && o_tx_en == 2'h0) else $error("reset left output");
endmodule
bind dtts_tone_source dtts_checker u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_enable(i_enable), .i_tone_sel(i_tone_sel), .i_slot(i_slot),
  .i_frame(i_frame), .i_bit_clk(i_bit_clk), .o_tx_data(o_tx_data),
  .o_tx_en(o_tx_en), .o_sel_scan(o_sel_scan), .o_active(o_active));
`default_nettype wire

// ===== testbench/dtts_shelf_model.sv
// Purpose: Free-running shelf PCM timing and word capture.
// Assumes: Strobe levels stand four clocks.
// Notes:   Half of each 128 clocks is idle, so lines settle.
`default_nettype none
module dtts_shelf_model
  import dtts_pkg::*;
(
  input  wire logic        [1:0] i_bits,  // Serial bits.
  input  wire logic              i_clk,   // Clock.
  output logic                   o_frame, // Frame strobe.
  output logic                   o_bclk,  // Bit clock.
  output logic                   o_done,  // Words ready.
  output logic [SAMPLE_W-1:0]    o_w0,    // Trunk 0 word.
  output logic [SAMPLE_W-1:0]    o_w1     // Trunk 1 word.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] cnt_ff = 7'h00;
  // Strobe, then seven bit edges eight clocks apart.
  assign o_frame = cnt_ff[6:2] == 5'h00;
  assign o_bclk = !cnt_ff[6] && cnt_ff[5:3] != 3'h0 && !cnt_ff[2];
  assign o_done = cnt_ff == 7'h3f;
  // Sample six clocks after each edge, past the output lag.
  always_ff @(posedge i_clk)
  begin
    cnt_ff <= cnt_ff + 7'h01;
    if (!cnt_ff[6] && cnt_ff[2:0] == 3'h6)
    begin
      o_w0 <= {o_w0[6:0], i_bits[0]};
      o_w1 <= {o_w1[6:0], i_bits[1]};
    end
  end
endmodule
`default_nettype wire

// ===== testbench/dtts_tone_source_bench.sv
// Purpose: Self-checking bench for the tone source.
// Assumes: Long silence and tone spans are cut to frames.
// Notes:   The tone is judged by its period, not values.
`default_nettype none
module dtts_tone_source_bench
  import dtts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] en = 2'h0, sel = 2'h0, slot = 2'h0, txd, txen, scan;
  logic       frm, bclk, act, done;
  logic [7:0] w0, w1, first;
  int         mismatches = 0, checks = 0;
  dtts_tone_source dut (.i_clk(clk), .i_rst(rst), .i_enable(en),
    .i_tone_sel(sel), .i_slot(slot), .i_frame(frm), .i_bit_clk(bclk),
    .o_tx_data(txd), .o_tx_en(txen), .o_sel_scan(scan), .o_active(act));
  dtts_shelf_model shelf (.i_bits(txd), .i_clk(clk), .o_frame(frm),
    .o_bclk(bclk), .o_done(done), .o_w0(w0), .o_w1(w1));
  initial forever #2 clk = ~clk;
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Waits for the next captured word, at a settled edge.
  task automatic frame;
    int n;
    @(negedge clk);
    for (n = 0; n < 300 && done !== 1'b1; n++) @(negedge clk);
    if (done !== 1'b1) mismatches++;
    if (done !== 1'b1) end_sim();
  endtask
  // Waits out the frame after a change; that frame is whole only when the change follows a frame end.
  task automatic drive(logic [1:0] e, logic [1:0] s, logic [1:0] l);
    @(posedge clk);
    en <= e;
    sel <= s;
    slot <= l;
    frame();
  endtask
  task automatic t_quiet;
    drive(2'h3, 2'h0, 2'h3);
    frame();
    chk("active", 8'h01, {7'h0, act});
    chk("drive", 8'h03, {6'h0, txen});
    chk("quiet0", PCM_ZERO, w0);
    chk("quiet1", PCM_ZERO, w1);
  endtask
  task automatic t_tone;
    int n, moved, loud;
    logic [7:0] second;
    moved = 0;
    loud = 0;
    frame();
    drive(2'h3, 2'h1, 2'h3);
    chk("scan", 8'h01, {6'h0, scan});
    frame();
    first = w0;
    for (n = 0; n < ROM_DEPTH; n++)
    begin
      frame();
      if (n == 0)
        second = w0;
      moved += (w0 !== first);
      loud += (w0 !== PCM_ZERO);
      chk("other", PCM_ZERO, w1);
    end
    chk("wrap", first, w0);
    chk("moved", 8'h01, {7'h0, moved > 0});
    chk("loud", 8'h01, {7'h0, loud > 0});
    // A full table later, the second trunk must carry the same sample.
    drive(2'h3, 2'h2, 2'h3);
    chk("tone1", second, w1);
    chk("swap0", PCM_ZERO, w0);
    drive(2'h3, 2'h0, 2'h3);
    frame();
    chk("after", PCM_ZERO, w0);
  endtask
  task automatic t_slot;
    drive(2'h3, 2'h0, 2'h2);
    chk("slot", 8'h02, {6'h0, txen});
    drive(2'h0, 2'h0, 2'h2);
    chk("idle", 8'h00, {7'h0, act});
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_quiet();
    t_tone();
    t_slot();
    end_sim();
  end
endmodule
`default_nettype wire
